/* pkg/pci_bridge_err_params.svh */
`ifndef PCI_BRIDGE_ERR_PARAMS_SVH
`define PCI_BRIDGE_ERR_PARAMS_SVH

// register indices on both configuration ports
`define IDX_INTERRUPT_PIN_ID 8'h00
`define IDX_MIN_GRANT 8'h01
`define IDX_MAX_LATENCY 8'h02
`define IDX_BUS_INTERRUPT_CTRL 8'h03
`define IDX_ERROR_ENABLE 8'h04
`define IDX_ERROR_STATUS 8'h05

// fixed read values
`define VAL_INTERRUPT_PIN_ID 8'h01
`define VAL_MIN_GRANT 8'h00
`define VAL_MAX_LATENCY 8'h00
`define VAL_UNMAPPED 8'h00

// reset values
`define RST_BUS_INTERRUPT_CTRL 1'b0
`define RST_ERROR_ENABLE 7'h00
`define RST_ERROR_STATUS 5'h00

// interrupt control field
`define POS_ASSERT_BUS_INTERRUPT 0

// error enable fields
`define POS_TARGET_ABORT_ERR_EN 6
`define POS_SLAVE_ERR_RESP_HI 5
`define POS_SLAVE_ERR_RESP_LO 4
`define POS_MASTER_ERR_DETECT_EN 3
`define POS_SLAVE_ERR_ASSERT_CTL 2
`define POS_WRITE_PARITY_SERR_CTL 1
`define POS_MASTER_ABORT_ERR_EN 0
`define WIDTH_ERROR_ENABLE 7

// error status fields
`define POS_SERR_ON_BUS_ERR_FLAG 4
`define POS_MASTER_BUS_ERR_SEEN 3
`define POS_SLAVE_ERR_EVENT_FLAG 2
`define POS_WRITE_PARITY_SERR_FLAG 1
`define POS_UNSUPPORTED_REQ_FLAG 0
`define WIDTH_ERROR_STATUS 5

// interrupt pin path latency in clocks
`define INT_PIN_STAGES 2

`endif

/* pkg/pci_bridge_err_pkg.sv */
package pci_bridge_err_pkg;

  // one configuration access, taken in the cycle req is high
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_type;

  // one-cycle error events from the bridge datapaths
  typedef struct packed {
    logic pci_target_abort;
    logic pci_master_abort;
    logic lb_master_err;
    logic lb_slave_err;
    logic pci_wr_parity_err;
    logic lb_unsupported_req;
  } err_event_type;

  typedef enum logic [1:0] {
    RESP_NONE = 2'b00,
    RESP_SERR = 2'b01,
    RESP_ABORT = 2'b10,
    RESP_BOTH = 2'b11
  } slave_err_resp_type;

endpackage

/* rtl/int_pin_driver.sv */
`timescale 1ns/1ns
module int_pin_driver #(
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // request level
  input wire logic assert_i,
  // open-drain pin
  output logic pin_n_o,
  output logic pin_oe_o
);

  logic [STAGES-1:0] pipe_reg;

  // fixed latency keeps the pin glitch free and registered
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= {pipe_reg[STAGES-2:0], assert_i};
    end
  end

  // open drain: only ever pull low, release otherwise
  assign pin_oe_o = pipe_reg[STAGES-1];
  assign pin_n_o = 1'b0;

endmodule

/* rtl/pci_bridge_intr_error_regs.sv */
`timescale 1ns/1ns
`include "pci_bridge_err_params.svh"
module pci_bridge_intr_error_regs
  import pci_bridge_err_pkg::*;
#(
  parameter int INT_STAGES = `INT_PIN_STAGES
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  // local bus configuration port
  input wire cfg_req_type LB_CFG_I,
  output logic [7:0] LB_CFG_RDATA_O,
  output logic LB_CFG_ACK_O,
  // pci configuration port
  input wire cfg_req_type PCI_CFG_I,
  output logic [7:0] PCI_CFG_RDATA_O,
  output logic PCI_CFG_ACK_O,
  // error events and qualifiers
  input wire err_event_type ERR_EVENT_I,
  input wire logic CMD_SERR_ENABLE_I,
  input wire logic TARGET_READ_I,
  input wire logic ASYNC_CLK_MODE_I,
  // local bus responses
  output logic LB_SLAVE_ERR_O,
  output logic LB_MASTER_ERR_DET_O,
  // pci target responses
  output logic TARGET_ABORT_O,
  // pci pins, open drain
  output logic SERR_N_O,
  output logic SERR_OE_O,
  output logic PERR_N_O,
  output logic PERR_OE_O,
  output logic INTA_N_O,
  output logic INTA_OE_O
);

  // stored state
  logic int_ctrl_reg;
  logic int_ctrl_next;
  logic [`WIDTH_ERROR_ENABLE-1:0] err_en_reg;
  logic [`WIDTH_ERROR_ENABLE-1:0] err_en_next;
  logic [`WIDTH_ERROR_STATUS-1:0] err_sts_reg;
  logic [`WIDTH_ERROR_STATUS-1:0] err_sts_next;

  // port answers
  logic [7:0] lb_rdata_reg;
  logic [7:0] pci_rdata_reg;
  logic lb_ack_reg;
  logic pci_ack_reg;

  // registered responses
  logic lb_slave_err_reg;
  logic lb_master_det_reg;
  logic target_abort_reg;
  logic serr_reg;
  logic perr_reg;

  // read mux shared by both ports
  function automatic logic [7:0] read_value(
    input logic [7:0] idx,
    input logic ictl,
    input logic [`WIDTH_ERROR_ENABLE-1:0] en,
    input logic [`WIDTH_ERROR_STATUS-1:0] sts
  );
    logic [7:0] v;
    v = `VAL_UNMAPPED;
    unique case (idx)
      `IDX_INTERRUPT_PIN_ID: v = `VAL_INTERRUPT_PIN_ID;
      `IDX_MIN_GRANT: v = `VAL_MIN_GRANT;
      `IDX_MAX_LATENCY: v = `VAL_MAX_LATENCY;
      `IDX_BUS_INTERRUPT_CTRL: v = {7'h00, ictl};
      `IDX_ERROR_ENABLE: v = {1'b0, en};
      `IDX_ERROR_STATUS: v = {3'h0, sts};
      default: v = `VAL_UNMAPPED;
    endcase
    return v;
  endfunction

  // write hit on one register index
  function automatic logic write_hit(
    input cfg_req_type r,
    input logic [7:0] idx
  );
    return r.req && r.we && (r.addr == idx);
  endfunction

  // field decode
  wire slave_err_resp_type resp_sel = slave_err_resp_type'(
    err_en_reg[`POS_SLAVE_ERR_RESP_HI:`POS_SLAVE_ERR_RESP_LO]);
  wire target_abort_en = err_en_reg[`POS_TARGET_ABORT_ERR_EN];
  wire master_detect_en = err_en_reg[`POS_MASTER_ERR_DETECT_EN];
  wire slave_assert_ctl = err_en_reg[`POS_SLAVE_ERR_ASSERT_CTL];
  wire parity_serr_ctl = err_en_reg[`POS_WRITE_PARITY_SERR_CTL];
  wire master_abort_en = err_en_reg[`POS_MASTER_ABORT_ERR_EN];

  // write decode
  wire lb_wr_ictl = write_hit(LB_CFG_I, `IDX_BUS_INTERRUPT_CTRL);
  wire pci_wr_ictl = write_hit(PCI_CFG_I, `IDX_BUS_INTERRUPT_CTRL);
  wire lb_wr_en = write_hit(LB_CFG_I, `IDX_ERROR_ENABLE);
  wire pci_wr_en = write_hit(PCI_CFG_I, `IDX_ERROR_ENABLE);
  wire lb_wr_sts = write_hit(LB_CFG_I, `IDX_ERROR_STATUS);
  wire pci_wr_sts = write_hit(PCI_CFG_I, `IDX_ERROR_STATUS);

  // local bus master error path
  wire master_err_detected = ERR_EVENT_I.lb_master_err && master_detect_en;
  wire resp_serr = (resp_sel == RESP_SERR) || (resp_sel == RESP_BOTH);
  wire resp_abort = (resp_sel == RESP_ABORT) || (resp_sel == RESP_BOTH);
  wire bus_err_serr = master_err_detected && resp_serr;
  // async mode cannot hold the pci read open, so abort is withheld there
  wire bus_err_abort = master_err_detected && resp_abort && TARGET_READ_I &&
                       !ASYNC_CLK_MODE_I;

  // pci master abort and target abort as local bus errors
  wire tabort_err = ERR_EVENT_I.pci_target_abort && target_abort_en;
  wire mabort_err = ERR_EVENT_I.pci_master_abort && master_abort_en;
  wire slave_err_event = ERR_EVENT_I.lb_slave_err || tabort_err || mabort_err;
  wire slave_err_drive = slave_err_event && slave_assert_ctl;

  // pci write data parity error as target
  wire parity_serr = ERR_EVENT_I.pci_wr_parity_err && parity_serr_ctl &&
                     CMD_SERR_ENABLE_I;

  // status set sources
  logic [`WIDTH_ERROR_STATUS-1:0] sts_set;
  logic [`WIDTH_ERROR_STATUS-1:0] sts_clr;

  always_comb begin
    sts_set = '0;
    sts_set[`POS_SERR_ON_BUS_ERR_FLAG] = bus_err_serr;
    sts_set[`POS_MASTER_BUS_ERR_SEEN] = ERR_EVENT_I.lb_master_err;
    sts_set[`POS_SLAVE_ERR_EVENT_FLAG] = slave_err_event;
    sts_set[`POS_WRITE_PARITY_SERR_FLAG] = parity_serr;
    sts_set[`POS_UNSUPPORTED_REQ_FLAG] = ERR_EVENT_I.lb_unsupported_req;
  end

  // ones written on either port clear; zeros leave bits alone
  always_comb begin
    sts_clr = '0;
    if (lb_wr_sts) begin
      sts_clr = sts_clr | LB_CFG_I.wdata[`WIDTH_ERROR_STATUS-1:0];
    end
    if (pci_wr_sts) begin
      sts_clr = sts_clr | PCI_CFG_I.wdata[`WIDTH_ERROR_STATUS-1:0];
    end
  end

  // an event in the clearing cycle survives the clear
  assign err_sts_next = (err_sts_reg & ~sts_clr) | sts_set;

  // both masters may write; the local bus wins a same-cycle collision
  always_comb begin
    int_ctrl_next = int_ctrl_reg;
    if (lb_wr_ictl) begin
      int_ctrl_next = LB_CFG_I.wdata[`POS_ASSERT_BUS_INTERRUPT];
    end else if (pci_wr_ictl) begin
      int_ctrl_next = PCI_CFG_I.wdata[`POS_ASSERT_BUS_INTERRUPT];
    end
  end

  always_comb begin
    err_en_next = err_en_reg;
    if (lb_wr_en) begin
      err_en_next = LB_CFG_I.wdata[`WIDTH_ERROR_ENABLE-1:0];
    end else if (pci_wr_en) begin
      err_en_next = PCI_CFG_I.wdata[`WIDTH_ERROR_ENABLE-1:0];
    end
  end

  // register file
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      int_ctrl_reg <= `RST_BUS_INTERRUPT_CTRL;
      err_en_reg <= `RST_ERROR_ENABLE;
      err_sts_reg <= `RST_ERROR_STATUS;
    end else begin
      int_ctrl_reg <= int_ctrl_next;
      err_en_reg <= err_en_next;
      err_sts_reg <= err_sts_next;
    end
  end

  // read data is sampled before the same-cycle write lands
  wire [7:0] lb_rd_value = read_value(LB_CFG_I.addr, int_ctrl_reg, err_en_reg, err_sts_reg);
  wire [7:0] pci_rd_value = read_value(PCI_CFG_I.addr, int_ctrl_reg, err_en_reg, err_sts_reg);

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lb_ack_reg <= 1'b0;
      pci_ack_reg <= 1'b0;
      lb_rdata_reg <= 8'h00;
      pci_rdata_reg <= 8'h00;
    end else begin
      lb_ack_reg <= LB_CFG_I.req;
      pci_ack_reg <= PCI_CFG_I.req;
      if (LB_CFG_I.req && !LB_CFG_I.we) begin
        lb_rdata_reg <= lb_rd_value;
      end
      if (PCI_CFG_I.req && !PCI_CFG_I.we) begin
        pci_rdata_reg <= pci_rd_value;
      end
    end
  end

  assign LB_CFG_ACK_O = lb_ack_reg;
  assign PCI_CFG_ACK_O = pci_ack_reg;
  assign LB_CFG_RDATA_O = lb_rdata_reg;
  assign PCI_CFG_RDATA_O = pci_rdata_reg;

  // error responses, one registered pulse per event
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lb_slave_err_reg <= 1'b0;
      lb_master_det_reg <= 1'b0;
      target_abort_reg <= 1'b0;
      serr_reg <= 1'b0;
      perr_reg <= 1'b0;
    end else begin
      lb_slave_err_reg <= slave_err_drive;
      lb_master_det_reg <= master_err_detected;
      target_abort_reg <= bus_err_abort;
      serr_reg <= bus_err_serr || parity_serr;
      perr_reg <= parity_serr;
    end
  end

  // unsupported requests get no answer here; the local bus timeout ends them
  assign LB_SLAVE_ERR_O = lb_slave_err_reg;
  assign LB_MASTER_ERR_DET_O = lb_master_det_reg;
  assign TARGET_ABORT_O = target_abort_reg;

  // open drain: pull low while enabled, never drive high
  assign SERR_OE_O = serr_reg;
  assign SERR_N_O = 1'b0;
  assign PERR_OE_O = perr_reg;
  assign PERR_N_O = 1'b0;

  int_pin_driver #(
    .STAGES(INT_STAGES)
  ) u_int_pin (
    .clk_i(SYS_CLK_I),
    .nrst_i(NRST_I),
    .assert_i(int_ctrl_reg),
    .pin_n_o(INTA_N_O),
    .pin_oe_o(INTA_OE_O)
  );

endmodule

/* testbench/pci_bridge_err_assertions.sv */
`timescale 1ns/1ns
`include "pci_bridge_err_params.svh"
module pci_bridge_err_assertions
  import pci_bridge_err_pkg::*;
#(
  parameter int INT_STAGES = 2
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  // configuration ports
  input wire cfg_req_type LB_CFG_I,
  input wire logic [7:0] LB_CFG_RDATA_O,
  input wire logic LB_CFG_ACK_O,
  input wire cfg_req_type PCI_CFG_I,
  input wire logic [7:0] PCI_CFG_RDATA_O,
  // events
  input wire err_event_type ERR_EVENT_I,
  input wire logic CMD_SERR_ENABLE_I,
  input wire logic TARGET_READ_I,
  input wire logic ASYNC_CLK_MODE_I,
  // responses
  input wire logic LB_SLAVE_ERR_O,
  input wire logic LB_MASTER_ERR_DET_O,
  input wire logic TARGET_ABORT_O,
  input wire logic SERR_OE_O,
  input wire logic PERR_OE_O,
  input wire logic INTA_OE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  // shadow copies of the interrupt control and error enable bits; local bus wins a same-cycle write
  logic ictl_reg;
  logic [6:0] en_reg;
  wire lb_w = LB_CFG_I.req && LB_CFG_I.we;
  wire pci_w = PCI_CFG_I.req && PCI_CFG_I.we;
  wire lb_ic = lb_w && LB_CFG_I.addr == `IDX_BUS_INTERRUPT_CTRL;
  wire pci_ic = pci_w && PCI_CFG_I.addr == `IDX_BUS_INTERRUPT_CTRL;
  wire lb_en = lb_w && LB_CFG_I.addr == `IDX_ERROR_ENABLE;
  wire pci_en = pci_w && PCI_CFG_I.addr == `IDX_ERROR_ENABLE;
  wire lbm = ERR_EVENT_I.lb_master_err;
  // serr and abort answers hang off detection, so both need the detect enable
  wire det_ev = lbm && en_reg[3];
  wire slv_ev = ERR_EVENT_I.lb_slave_err || (ERR_EVENT_I.pci_target_abort && en_reg[6])
    || (ERR_EVENT_I.pci_master_abort && en_reg[0]);
  wire par_ev = ERR_EVENT_I.pci_wr_parity_err && en_reg[1] && CMD_SERR_ENABLE_I;
  wire pci_rd = PCI_CFG_I.req && !PCI_CFG_I.we;
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ictl_reg <= 1'b0;
      en_reg <= 7'h00;
    end else begin
      if (lb_ic || pci_ic) ictl_reg <= lb_ic ? LB_CFG_I.wdata[0] : PCI_CFG_I.wdata[0];
      if (lb_en || pci_en) en_reg <= lb_en ? LB_CFG_I.wdata[6:0] : PCI_CFG_I.wdata[6:0];
    end
  end
  AST_PIN_ID: assert property (
    LB_CFG_I.req && !LB_CFG_I.we && LB_CFG_I.addr == `IDX_INTERRUPT_PIN_ID
    |=> LB_CFG_ACK_O && LB_CFG_RDATA_O == `VAL_INTERRUPT_PIN_ID) else $error("pin id read");
  AST_FIXED_ZERO: assert property (
    pci_rd && PCI_CFG_I.addr inside {`IDX_MIN_GRANT, `IDX_MAX_LATENCY}
    |=> PCI_CFG_RDATA_O == 8'h00) else $error("fixed zero read");
  AST_ICTL_READ: assert property (
    pci_rd && PCI_CFG_I.addr == `IDX_BUS_INTERRUPT_CTRL
    |=> PCI_CFG_RDATA_O == {7'h00, $past(ictl_reg)}) else $error("interrupt ctrl read");
  AST_INT_PIN: assert property (
    INTA_OE_O == $past(ictl_reg, INT_STAGES)) else $error("interrupt pin lag");
  AST_DETECT: assert property (
    det_ev |=> LB_MASTER_ERR_DET_O) else $error("detect missing");
  AST_NO_DETECT: assert property (
    !det_ev |=> !LB_MASTER_ERR_DET_O) else $error("detect spurious");
  AST_SLAVE_ERR: assert property (
    LB_SLAVE_ERR_O == $past(slv_ev && en_reg[2])) else $error("slave error");
  AST_SERR: assert property (
    SERR_OE_O == $past((det_ev && en_reg[4]) || par_ev)) else $error("system error pin");
  AST_TABORT: assert property (
    TARGET_ABORT_O == $past(det_ev && en_reg[5] && TARGET_READ_I && !ASYNC_CLK_MODE_I))
    else $error("target abort");
  AST_PERR: assert property (
    PERR_OE_O == $past(par_ev)) else $error("parity pin");
  AST_UNSUP: assert property (
    ERR_EVENT_I == err_event_type'(6'h01) |=> !(LB_SLAVE_ERR_O || SERR_OE_O || TARGET_ABORT_O))
    else $error("unsupported request answered");
  COV_SERR: cover property (det_ev && en_reg[4]);
  COV_PAR: cover property (par_ev);
  COV_INT: cover property ($rose(INTA_OE_O));
  COV_TABORT: cover property (TARGET_ABORT_O);
endmodule
bind pci_bridge_intr_error_regs pci_bridge_err_assertions #(.INT_STAGES(INT_STAGES)) u_chk (
  .SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .LB_CFG_I(LB_CFG_I), .LB_CFG_RDATA_O(LB_CFG_RDATA_O),
  .LB_CFG_ACK_O(LB_CFG_ACK_O), .PCI_CFG_I(PCI_CFG_I), .PCI_CFG_RDATA_O(PCI_CFG_RDATA_O),
  .ERR_EVENT_I(ERR_EVENT_I), .CMD_SERR_ENABLE_I(CMD_SERR_ENABLE_I),
  .TARGET_READ_I(TARGET_READ_I), .ASYNC_CLK_MODE_I(ASYNC_CLK_MODE_I),
  .LB_SLAVE_ERR_O(LB_SLAVE_ERR_O), .LB_MASTER_ERR_DET_O(LB_MASTER_ERR_DET_O),
  .TARGET_ABORT_O(TARGET_ABORT_O), .SERR_OE_O(SERR_OE_O), .PERR_OE_O(PERR_OE_O),
  .INTA_OE_O(INTA_OE_O));

/* testbench/pin_pullup_model.sv */
`timescale 1ns/1ns
module pin_pullup_model (
  // open-drain drivers
  input wire logic serr_n_i,
  input wire logic serr_oe_i,
  input wire logic perr_n_i,
  input wire logic perr_oe_i,
  input wire logic inta_n_i,
  input wire logic inta_oe_i,
  // resolved line levels
  output logic serr_o,
  output logic perr_o,
  output logic inta_o
);
  // bus pull-ups take each line high once released
  assign serr_o = serr_oe_i ? serr_n_i : 1'b1;
  assign perr_o = perr_oe_i ? perr_n_i : 1'b1;
  assign inta_o = inta_oe_i ? inta_n_i : 1'b1;
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ns
`include "pci_bridge_err_params.svh"
module testbench
  import pci_bridge_err_pkg::*;
();
  localparam int ST = 2;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cfg_req_type lb = '0;
  cfg_req_type pc = '0;
  err_event_type ev = '0;
  logic cmd = 1'b0;
  logic trd = 1'b0;
  logic asy = 1'b0;
  logic [7:0] lb_rd, pc_rd;
  logic lb_ack, pc_ack, slv, det, tab, serr_n, serr_oe, perr_n, perr_oe, inta_n, inta_oe;
  logic serr_w, perr_w, inta_w;
  int n_fail = 0;
  int checks = 0;
  int ic = 0;
  int en = 0;
  int st = 0;
  always #20 clk = ~clk;
  pci_bridge_intr_error_regs #(.INT_STAGES(ST)) dut (
    .SYS_CLK_I(clk), .NRST_I(nrst), .LB_CFG_I(lb), .LB_CFG_RDATA_O(lb_rd), .LB_CFG_ACK_O(lb_ack),
    .PCI_CFG_I(pc), .PCI_CFG_RDATA_O(pc_rd), .PCI_CFG_ACK_O(pc_ack), .ERR_EVENT_I(ev),
    .CMD_SERR_ENABLE_I(cmd), .TARGET_READ_I(trd), .ASYNC_CLK_MODE_I(asy), .LB_SLAVE_ERR_O(slv),
    .LB_MASTER_ERR_DET_O(det), .TARGET_ABORT_O(tab), .SERR_N_O(serr_n), .SERR_OE_O(serr_oe),
    .PERR_N_O(perr_n), .PERR_OE_O(perr_oe), .INTA_N_O(inta_n), .INTA_OE_O(inta_oe));
  pin_pullup_model u_pins (
    .serr_n_i(serr_n), .serr_oe_i(serr_oe), .perr_n_i(perr_n), .perr_oe_i(perr_oe),
    .inta_n_i(inta_n), .inta_oe_i(inta_oe), .serr_o(serr_w), .perr_o(perr_w), .inta_o(inta_w));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp5(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one idle cycle between accesses keeps each request edge clean
  task automatic cfg(input bit p, input bit we, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] rd);
    @(posedge clk);
    #2;
    if (p) pc = '{1'b1, we, a, d};
    else lb = '{1'b1, we, a, d};
    @(posedge clk);
    #2;
    lb = '0;
    pc = '0;
    cmp5({4'h0, p ? pc_ack : lb_ack}, 5'h01);
    rd = p ? pc_rd : lb_rd;
  endtask
  task automatic wr(input bit p, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rd;
    cfg(p, 1'b1, a, d, rd);
  endtask
  task automatic rd_chk(input bit p, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] rd;
    cfg(p, 1'b0, a, 8'h00, rd);
    cmp8(rd, exp);
  endtask
  function automatic logic [7:0] rv(input int a);
    case (a)
      0: rv = `VAL_INTERRUPT_PIN_ID;
      3: rv = ic[7:0];
      4: rv = en[7:0];
      5: rv = st[7:0];
      default: rv = 8'h00;
    endcase
  endfunction
  task automatic int_chk(input logic lvl);
    repeat (ST - 1) @(posedge clk);
    #2;
    cmp5({4'h0, inta_w}, {4'h0, lvl});
    @(posedge clk);
    #2;
    cmp5({4'h0, inta_w}, {4'h0, ~lvl});
  endtask
  task automatic fire(input logic [5:0] e);
    logic s, p, d;
    logic [4:0] x;
    @(posedge clk);
    #2;
    ev = err_event_type'(e);
    @(posedge clk);
    #2;
    ev = '0;
    s = e[2] || (e[5] && en[6]) || (e[4] && en[0]);
    p = e[1] && en[1] && cmd;
    // serr and abort answers to a master error only follow its detection; the parity serr does not
    d = e[3] && en[3];
    x = {s && en[2], d, d && en[5] && trd && !asy, !((d && en[4]) || p), !p};
    cmp5({slv, det, tab, serr_w, perr_w}, x);
    st |= {d && en[4], e[3], s, p, e[0]};
  endtask
  task automatic give_verdict;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
  initial begin
    int k, a;
    logic [7:0] m;
    void'($urandom(46541));
    repeat (12) @(posedge clk);
    #2;
    nrst = 1'b1;
    for (k = 0; k < 2; k++) begin
      for (a = 0; a < 8; a++) if (a < 3 || a > 5) wr(k[0], a[7:0], 8'($urandom));
      for (a = 0; a < 8; a++) rd_chk(k[0], a[7:0], rv(a));
    end
    $display("fixed register test done");
    // each port sets the bit once and clears it once
    for (k = 0; k < 2; k++) begin
      wr(k[0], `IDX_BUS_INTERRUPT_CTRL, 8'hff);
      ic = 1;
      int_chk(1'b1);
      rd_chk(!k[0], `IDX_BUS_INTERRUPT_CTRL, rv(3));
      wr(!k[0], `IDX_BUS_INTERRUPT_CTRL, 8'hfe);
      ic = 0;
      int_chk(1'b0);
      rd_chk(k[0], `IDX_BUS_INTERRUPT_CTRL, rv(3));
    end
    $display("interrupt test done");
    for (k = 0; k < 24; k++) begin
      asy = 1'($urandom);
      m = (8'($urandom) & 8'hcf) | 8'((k % 4) << 4);
      // software keeps abort codes out of async mode
      if (asy) m[5] = 1'b0;
      wr(k[0], `IDX_ERROR_ENABLE, m);
      en = m & 8'h7f;
      rd_chk(!k[0], `IDX_ERROR_ENABLE, rv(4));
      cmd = 1'($urandom);
      trd = 1'($urandom);
      fire(k < 6 ? 6'h20 >> k : 6'($urandom));
      rd_chk(k[0], `IDX_ERROR_STATUS, rv(5));
      m = 8'($urandom);
      wr(!k[0], `IDX_ERROR_STATUS, m);
      st &= ~int'(m);
      rd_chk(k[0], `IDX_ERROR_STATUS, rv(5));
    end
    $display("error test done");
    give_verdict();
  end
endmodule
